// ===== rtl/flash_cfg_pkg.sv
package flash_cfg_pkg;
  // Command opcodes on the serial link
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_EN = 8'h50;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_ONE = 8'h05;
  localparam logic [7:0] OP_READ_TWO = 8'h35;
  localparam logic [7:0] OP_READ_THREE = 8'h15;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;
  // Field positions inside the status registers
  localparam int BUSY_BIT = 0;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int PROTECT_LOW_BIT = 7;
  localparam int PROTECT_HIGH_BIT = 0;
  localparam int QUAD_ENABLE_BIT = 1;
  localparam int LOCK_LSB = 2;
  localparam int COMPLEMENT_BIT = 6;
  localparam int PAUSED_BIT = 7;
  localparam int LATENCY_LSB = 0;
  // Writable configuration masks
  localparam logic [7:0] ONE_CFG_MASK = 8'hfc;
  localparam logic [7:0] TWO_CFG_MASK = 8'h43;
  localparam logic [7:0] THREE_MASK = 8'h7f;
  // Reset values
  localparam logic [7:0] ONE_RESET = 8'h00;
  localparam logic [7:0] TWO_RESET = 8'h00;
  localparam logic [7:0] THREE_RESET = 8'h00;
  localparam logic [3:0] LOCK_RESET = 4'h1;
  // Legacy read latency figures
  localparam logic [3:0] LEGACY_FAST_DUMMY = 4'h8;
  localparam logic [3:0] LEGACY_DIO_DUMMY = 4'h0;
  localparam logic [3:0] LEGACY_QIO_DUMMY = 4'h4;
  localparam logic [3:0] DIO_MODE_CYCLES = 4'h4;
  localparam logic [3:0] QIO_MODE_CYCLES = 4'h2;
  // Host register map, byte addresses
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] DATA_OFFSET = 8'h04;
  localparam logic [7:0] STAT_OFFSET = 8'h08;
  localparam logic [7:0] PINS_OFFSET = 8'h0c;
  localparam logic [1:0] PINS_RESET = 2'h3;
  // Serial clock half period in pclk cycles
  localparam int SCK_HALF = 8;
endpackage

// ===== rtl/spi_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic wp_n;
  logic hold_n;
  modport host_end (output sck, output cs_n, output mosi, output wp_n, output hold_n,
    input miso);
  modport flash_end (input sck, input cs_n, input mosi, input wp_n, input hold_n,
    output miso);
endinterface
`default_nettype wire

// ===== rtl/flash_status_protect_config.sv
// What this block does
// R1: protect bits at status two bit0, one bit7
// R2: protect 00 ignores pin, latch allows writes
// R3: protect 01 with pin low locks
// R4: protect 01 with pin high allows writes
// R5: protect 10 locks; power/reset clears it
// R6: protect 11 locks status forever
// R7: busy, latch, paused are read-only
// R8: write enable then write targets non-volatile
// R9: volatile enable targets volatile copies only
// R10: volatile write leaves lock bits alone
// R11: volatile status three ignores protect bits
// R12: suspend command sets paused flag
// R13: resume or power cycle clears paused
// R14: lock bits at two[5:2], settable singly
// R15: set lock bit never clears again
// R16: lock zero is factory set
// R17: quad enable zero keeps protect, hold
// R18: quad enable one disables protect, hold
// R19: host avoids quad enable on tied pins
// R20: latency code drives fast read latency
// R21: codes 1-15 literal, zero means legacy
// R22: legacy dummy and mode cycle counts; only the dummy counts are output here
// R23: host picks latency fitting its clock
// R24: locked bits kept, unlocked bits updated
`timescale 1ns/100ps
`default_nettype none
module flash_status_protect_config (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial link
  spi_link_if.flash_end link,
  // Array side
  input wire logic array_busy,
  input wire logic power_cycle,
  // Configuration seen by the array and read engine
  output logic suspended,
  output logic quad_lines_enable,
  output logic hold_active,
  output logic [3:0] secure_read_only,
  output logic [3:0] read_latency_code,
  output logic [3:0] fast_dummy,
  output logic [3:0] dio_dummy,
  output logic [3:0] qio_dummy
);
  // Pin synchronisers: wp_n, hold_n, mosi, cs_n, sck
  logic [4:0] pin_raw, s1_q, s2_q;
  logic sck_prev_q, cs_prev_q;
  // Receive side
  logic [2:0] bit_q;
  logic [7:0] shift_q, op_q, wr1_q, wr2_q, wr3_q;
  logic [1:0] nbytes_q;
  logic have_op_q;
  // Status storage
  logic [7:0] nv1_q, nv2_q, vol1_q, vol2_q, three_q;
  logic [3:0] lock_q;
  logic std_en_q, vwel_q, susp_q;
  // Transmit side
  logic [7:0] tx_q;
  logic miso_q;

  assign pin_raw = {link.wp_n, link.hold_n, link.mosi, link.cs_n, link.sck};

  // Two flops per pin before any logic looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 5'h1a;
      s2_q <= 5'h1a;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      sck_prev_q <= s2_q[0];
      cs_prev_q <= s2_q[1];
    end
  end

  // Decoded link events
  wire sck_s = s2_q[0];
  wire cs_s = s2_q[1];
  wire mosi_s = s2_q[2];
  wire hold_s = s2_q[3];
  wire wp_s = s2_q[4];
  wire quad_en = vol2_q[flash_cfg_pkg::QUAD_ENABLE_BIT];
  // R17: hold pin active
  // R18: quad mode drops hold
  wire paused = ~quad_en & ~hold_s;
  wire sck_rise = ~cs_s & ~paused & sck_s & ~sck_prev_q;
  wire sck_fall = ~cs_s & ~paused & ~sck_s & sck_prev_q;
  wire cs_rise = cs_s & ~cs_prev_q;
  wire [7:0] byte_in = {shift_q[6:0], mosi_s};
  wire byte_done = sck_rise & (bit_q == 3'h7);

  // Command decode, executed when the host deselects on a byte boundary
  wire exec = cs_rise & have_op_q & (bit_q == 3'h0);
  wire ex_wren = exec & (op_q == flash_cfg_pkg::OP_WRITE_EN);
  wire ex_vwren = exec & (op_q == flash_cfg_pkg::OP_VOL_WRITE_EN);
  wire ex_wrdi = exec & (op_q == flash_cfg_pkg::OP_WRITE_DIS);
  wire ex_wrsr = exec & (op_q == flash_cfg_pkg::OP_WRITE_STATUS);
  wire ex_susp = exec & (op_q == flash_cfg_pkg::OP_SUSPEND);
  wire ex_resume = exec & (op_q == flash_cfg_pkg::OP_RESUME);
  wire ex_reset = exec & (op_q == flash_cfg_pkg::OP_SOFT_RESET);
  // A status write is refused while the array is busy
  wire wr_go = ex_wrsr & ~array_busy & (nbytes_q != 2'h0);
  wire wr_nv = wr_go & std_en_q;
  wire wr_vol = wr_go & vwel_q & ~std_en_q;

  // R1: protect pair location
  wire [1:0] srp = {vol2_q[flash_cfg_pkg::PROTECT_HIGH_BIT],
    vol1_q[flash_cfg_pkg::PROTECT_LOW_BIT]};
  wire wp_low = ~quad_en & ~wp_s;
  // R2: software protection
  // R3: pin low locks
  // R4: pin high unlocks
  // R5: lock-down state
  // R6: one-time lock
  wire locked = (srp == 2'b11) | (srp == 2'b10) | ((srp == 2'b01) & wp_low);

  // R24: masked merge keeps locked fields
  wire [7:0] new1 = (vol1_q & ~flash_cfg_pkg::ONE_CFG_MASK) |
    (wr1_q & flash_cfg_pkg::ONE_CFG_MASK);
  wire [7:0] new2 = (vol2_q & ~flash_cfg_pkg::TWO_CFG_MASK) |
    (wr2_q & flash_cfg_pkg::TWO_CFG_MASK);
  wire [7:0] nvn1 = (nv1_q & ~flash_cfg_pkg::ONE_CFG_MASK) |
    (wr1_q & flash_cfg_pkg::ONE_CFG_MASK);
  wire [7:0] nvn2 = (nv2_q & ~flash_cfg_pkg::TWO_CFG_MASK) |
    (wr2_q & flash_cfg_pkg::TWO_CFG_MASK);
  wire up1 = ~locked & (nbytes_q >= 2'h1);
  wire up2 = ~locked & (nbytes_q >= 2'h2);
  wire up3 = nbytes_q == 2'h3;
  // Power cycle or soft reset reload volatile copies
  wire reload = power_cycle | ex_reset;
  wire nv_lockdown = (nv2_q[flash_cfg_pkg::PROTECT_HIGH_BIT] == 1'b1) &
    (nv1_q[flash_cfg_pkg::PROTECT_LOW_BIT] == 1'b0);

  // Read-back values
  // R7: volatile read-only bits
  wire [7:0] rd1 = {vol1_q[7:2], std_en_q | vwel_q, array_busy};
  wire [7:0] rd2 = {susp_q, vol2_q[flash_cfg_pkg::COMPLEMENT_BIT], lock_q, vol2_q[1:0]};
  wire is_rd1 = byte_in == flash_cfg_pkg::OP_READ_ONE;
  wire is_rd2 = byte_in == flash_cfg_pkg::OP_READ_TWO;
  wire is_rd3 = byte_in == flash_cfg_pkg::OP_READ_THREE;
  wire [7:0] rd_sel = is_rd1 ? rd1 : is_rd2 ? rd2 : is_rd3 ? three_q : 8'h00;

  // Shift in command and data bytes, MSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      op_q <= 8'h00;
      have_op_q <= 1'b0;
      nbytes_q <= 2'h0;
      wr1_q <= 8'h00;
      wr2_q <= 8'h00;
      wr3_q <= 8'h00;
    end else if (cs_s) begin
      bit_q <= 3'h0;
      have_op_q <= 1'b0;
      nbytes_q <= 2'h0;
    end else if (sck_rise) begin
      bit_q <= bit_q + 3'h1;
      shift_q <= byte_in;
      if (byte_done && !have_op_q) begin
        op_q <= byte_in;
        have_op_q <= 1'b1;
      end else if (byte_done && nbytes_q != 2'h3) begin
        nbytes_q <= nbytes_q + 2'h1;
        if (nbytes_q == 2'h0) wr1_q <= byte_in;
        if (nbytes_q == 2'h1) wr2_q <= byte_in;
        if (nbytes_q == 2'h2) wr3_q <= byte_in;
      end
    end
  end

  // Write latches; any status write or disable clears both
  // R8: standard enable selects non-volatile
  // R9: volatile enable selects volatile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_en_q <= 1'b0;
      vwel_q <= 1'b0;
    end else if (reload || ex_wrdi || ex_wrsr) begin
      std_en_q <= 1'b0;
      vwel_q <= 1'b0;
    end else if (ex_wren) begin
      std_en_q <= 1'b1;
      vwel_q <= 1'b0;
    end else if (ex_vwren) begin
      vwel_q <= 1'b1;
    end
  end

  // R12: suspend sets paused flag
  // R13: resume or power cycle clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) susp_q <= 1'b0;
    else susp_q <= ex_susp | (susp_q & ~ex_resume & ~power_cycle);
  end

  // Non-volatile and volatile configuration copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv1_q <= flash_cfg_pkg::ONE_RESET;
      nv2_q <= flash_cfg_pkg::TWO_RESET;
      vol1_q <= flash_cfg_pkg::ONE_RESET;
      vol2_q <= flash_cfg_pkg::TWO_RESET;
      three_q <= flash_cfg_pkg::THREE_RESET;
    end else if (reload) begin
      // R5: lock-down returns to unprotected
      if (nv_lockdown) begin
        nv2_q[flash_cfg_pkg::PROTECT_HIGH_BIT] <= 1'b0;
        vol2_q <= nv2_q & ~8'h01;
      end else begin
        vol2_q <= nv2_q;
      end
      vol1_q <= nv1_q;
      if (power_cycle) three_q <= flash_cfg_pkg::THREE_RESET;
    end else begin
      // R8: non-volatile write updates both copies
      if (wr_nv && up1) begin
        nv1_q <= nvn1;
        vol1_q <= new1;
      end
      if (wr_nv && up2) begin
        nv2_q <= nvn2;
        vol2_q <= new2;
      end
      // R9: volatile write stays volatile
      if (wr_vol && up1) vol1_q <= new1;
      if (wr_vol && up2) vol2_q <= new2;
      // R11: status three ignores protection
      if ((wr_nv || wr_vol) && up3) three_q <= wr3_q & flash_cfg_pkg::THREE_MASK;
    end
  end

  // Lock bits are one-time: only ever OR-ed in
  // R10: volatile writes skip lock bits
  // R14: individual lock set
  // R15: never returns to zero
  // R16: lock zero factory set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_q <= flash_cfg_pkg::LOCK_RESET;
    else if (wr_nv && up2) lock_q <= lock_q | wr2_q[5:2];
  end

  // Status read-out; byte repeats while the host keeps clocking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (cs_s) begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (byte_done && !have_op_q) begin
      tx_q <= rd_sel;
    end else if (sck_fall) begin
      miso_q <= tx_q[7];
      tx_q <= {tx_q[6:0], tx_q[7]};
    end
  end
  assign link.miso = miso_q;

  // Registered view of the configuration for the read engine
  // R20: latency code out
  // R21: zero selects legacy
  // R22: legacy dummy counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspended <= 1'b0;
      quad_lines_enable <= 1'b0;
      hold_active <= 1'b0;
      secure_read_only <= flash_cfg_pkg::LOCK_RESET;
      read_latency_code <= 4'h0;
      fast_dummy <= flash_cfg_pkg::LEGACY_FAST_DUMMY;
      dio_dummy <= flash_cfg_pkg::LEGACY_DIO_DUMMY;
      qio_dummy <= flash_cfg_pkg::LEGACY_QIO_DUMMY;
    end else begin
      suspended <= susp_q;
      quad_lines_enable <= quad_en;
      hold_active <= paused;
      secure_read_only <= lock_q;
      read_latency_code <= three_q[3:0];
      fast_dummy <= (three_q[3:0] == 4'h0) ? flash_cfg_pkg::LEGACY_FAST_DUMMY : three_q[3:0];
      dio_dummy <= (three_q[3:0] == 4'h0) ? flash_cfg_pkg::LEGACY_DIO_DUMMY : three_q[3:0];
      qio_dummy <= (three_q[3:0] == 4'h0) ? flash_cfg_pkg::LEGACY_QIO_DUMMY : three_q[3:0];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/flash_cmd_host.sv
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_host #(
  parameter int HALF = flash_cfg_pkg::SCK_HALF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  spi_link_if.host_end link
);
  typedef enum logic [1:0] {IDLE, LOW, HIGH, DESEL} state_t;
  state_t state_q;
  logic [7:0] div_q;
  logic [5:0] bits_q;
  logic [31:0] tx_q;
  logic [7:0] rx_q;
  logic [1:0] pins_q;
  logic [23:0] data_q;
  logic miso1_q, miso2_q;
  logic sck_q, cs_n_q;

  // APB decode; one wait state gives registered read data
  wire acc = psel & penable;
  wire done = acc & pready;
  wire hit_ctrl = paddr == flash_cfg_pkg::CTRL_OFFSET;
  wire hit_data = paddr == flash_cfg_pkg::DATA_OFFSET;
  wire hit_stat = paddr == flash_cfg_pkg::STAT_OFFSET;
  wire hit_pins = paddr == flash_cfg_pkg::PINS_OFFSET;
  wire mapped = hit_ctrl | hit_data | hit_stat | hit_pins;
  wire busy = state_q != IDLE;
  wire start = done & pwrite & hit_ctrl & ~busy;
  wire [31:0] rd_mux = hit_data ? {8'h00, data_q} :
    hit_stat ? {16'h0000, rx_q, 7'h00, busy} :
    hit_pins ? {30'h0, pins_q} : 32'h0;
  wire tick = div_q == 8'(HALF - 1);

  // Bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 24'h0;
      pins_q <= flash_cfg_pkg::PINS_RESET;
    end else if (done && pwrite) begin
      if (hit_data) data_q <= pwdata[23:0];
      if (hit_pins) pins_q <= pwdata[1:0];
    end
  end

  // Returning data passes two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso1_q <= 1'b0;
      miso2_q <= 1'b0;
    end else begin
      miso1_q <= link.miso;
      miso2_q <= miso1_q;
    end
  end

  // Frame sequencer; sck made here by division, mode 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IDLE;
      div_q <= 8'h0;
      bits_q <= 6'h0;
      tx_q <= 32'h0;
      rx_q <= 8'h0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      div_q <= (state_q == IDLE || tick) ? 8'h0 : div_q + 8'h1;
      case (state_q)
        IDLE: begin
          if (start) begin
            tx_q <= {pwdata[7:0], data_q[7:0], data_q[15:8], data_q[23:16]};
            // Opcode plus len data bytes; the counter runs down to zero inclusive
            bits_q <= {1'b0, pwdata[9:8], 3'h7};
            cs_n_q <= 1'b0;
            state_q <= LOW;
          end
        end
        LOW: begin
          if (tick) begin
            sck_q <= 1'b1;
            rx_q <= {rx_q[6:0], miso2_q};
            state_q <= HIGH;
          end
        end
        HIGH: begin
          if (tick) begin
            sck_q <= 1'b0;
            tx_q <= {tx_q[30:0], 1'b0};
            bits_q <= bits_q - 6'h1;
            state_q <= (bits_q == 6'h0) ? DESEL : LOW;
          end
        end
        DESEL: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            state_q <= IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = tx_q[31];
  assign link.wp_n = pins_q[0];
  assign link.hold_n = pins_q[1];
endmodule
`default_nettype wire

// ===== verification/flash_status_protect_config_props.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_protect_config_props #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic wp_n,
  input wire logic hold_n
);
  logic [7:0] high_cnt_q;
  logic [7:0] low_cnt_q;
  logic [5:0] rise_cnt_q;

  // Phase lengths and rising edges counted inside a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt_q <= 8'h00;
      low_cnt_q <= 8'h00;
      rise_cnt_q <= 6'h00;
    end else begin
      high_cnt_q <= sck ? high_cnt_q + 8'h01 : 8'h00;
      low_cnt_q <= (!sck && !cs_n) ? low_cnt_q + 8'h01 : 8'h00;
      rise_cnt_q <= cs_n ? 6'h00 : rise_cnt_q + {5'h00, $rose(sck)};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Host side framing: clock rests low, halves last HALF cycles
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("sck high outside a frame");
  a_sck_high_len: assert property ($fell(sck) |-> high_cnt_q == HALF)
    else $error("sck high phase has wrong length");
  a_sck_low_len: assert property ($rose(sck) |-> low_cnt_q == HALF)
    else $error("sck low phase has wrong length");
  a_frame_tail_len: assert property ($rose(cs_n) |-> low_cnt_q == HALF)
    else $error("select released at wrong time after last edge");
  // Only whole bytes are sent, opcode plus at most three data bytes
  a_whole_bytes: assert property ($rose(cs_n) |->
    rise_cnt_q inside {6'h08, 6'h10, 6'h18, 6'h20})
    else $error("frame does not hold whole bytes");
  a_mosi_steady_high: assert property (sck |-> $stable(mosi))
    else $error("mosi moved while sck high");
  // Device side: data moves only in the low phase, line quiet when idle
  a_miso_low_phase: assert property ((!cs_n && $changed(miso)) |-> !sck)
    else $error("miso moved while sck high");
  a_miso_idle_zero: assert property (cs_n [*8] |-> !miso)
    else $error("miso not zero between frames");

  c_short_frame: cover property ($rose(cs_n) && rise_cnt_q == 6'h08);
  c_long_frame: cover property ($rose(cs_n) && rise_cnt_q == 6'h20);
  c_miso_one: cover property (!cs_n && miso);
  c_pins_low: cover property (!cs_n && !wp_n && !hold_n);
endmodule
`default_nettype wire

// ===== verification/flash_status_protect_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_protect_config_tb;
  typedef struct packed {
    logic [7:0] en;
    logic [1:0] len;
    logic [23:0] d;
    logic [7:0] rop;
    logic [7:0] exp;
  } row_t;
  // Bench drive and design outputs
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic array_busy = 1'b0;
  logic power_cycle = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic suspended;
  logic quad_lines_enable;
  logic hold_active;
  logic [3:0] secure_read_only, read_latency_code, fast_dummy, dio_dummy, qio_dummy;
  logic [31:0] rq;
  logic re;
  int error_cnt = 0;
  int tests_run = 0;
  logic [3:0] codes [3] = '{4'h1, 4'hf, 4'h0};
  // Enable, length, data bytes, read opcode, expected byte
  row_t rows [7] = '{
    '{8'h06, 2'h1, 24'h00003f, flash_cfg_pkg::OP_READ_ONE, 8'h3c},
    '{8'h50, 2'h2, 24'h000a3c, flash_cfg_pkg::OP_READ_TWO, 8'h06},
    '{8'h06, 2'h2, 24'h000000, flash_cfg_pkg::OP_READ_TWO, 8'h04},
    '{8'h50, 2'h3, 24'h050000, flash_cfg_pkg::OP_READ_THREE, 8'h05},
    '{8'h06, 2'h2, 24'h000800, flash_cfg_pkg::OP_READ_TWO, 8'h0c},
    '{8'h06, 2'h2, 24'h000000, flash_cfg_pkg::OP_READ_TWO, 8'h0c},
    '{8'h00, 2'h1, 24'h00007c, flash_cfg_pkg::OP_READ_ONE, 8'h00}};

  spi_link_if link();
  flash_cmd_host #(.HALF(flash_cfg_pkg::SCK_HALF)) u_flash_cmd_host (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  flash_status_protect_config u_flash_status_protect_config (.pclk(pclk),
    .presetn(presetn), .link(link), .array_busy(array_busy), .power_cycle(power_cycle),
    .suspended(suspended), .quad_lines_enable(quad_lines_enable),
    .hold_active(hold_active), .secure_read_only(secure_read_only),
    .read_latency_code(read_latency_code), .fast_dummy(fast_dummy),
    .dio_dummy(dio_dummy), .qio_dummy(qio_dummy));
  flash_status_protect_config_props #(.HALF(flash_cfg_pkg::SCK_HALF))
    u_flash_status_protect_config_props (.pclk(pclk), .presetn(presetn),
    .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .wp_n(link.wp_n), .hold_n(link.hold_n));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // Send one frame and wait until the host is idle; opcode 0 sends nothing
  task automatic cmd(input logic [7:0] op, input logic [1:0] len, input logic [23:0] d);
    int n;
    if (op === 8'h00) return;
    apb(1'b1, flash_cfg_pkg::DATA_OFFSET, {8'h00, d}, rq, re);
    apb(1'b1, flash_cfg_pkg::CTRL_OFFSET, {22'h0, len, op}, rq, re);
    n = 0;
    do begin
      apb(1'b0, flash_cfg_pkg::STAT_OFFSET, 32'h0, rq, re);
      n++;
    end while (rq[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      tally_and_finish();
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic wst(input logic [7:0] en, input logic [1:0] len, input logic [23:0] d);
    cmd(en, 2'h0, 24'h0);
    cmd(8'h01, len, d);
  endtask

  task automatic rs(input logic [7:0] op, input logic [7:0] exp);
    cmd(op, 2'h1, 24'h0);
    apb(1'b0, flash_cfg_pkg::STAT_OFFSET, 32'h0, rq, re);
    chk(rq[15:8], exp);
  endtask

  task automatic pins(input logic [1:0] v);
    apb(1'b1, flash_cfg_pkg::PINS_OFFSET, {30'h0, v}, rq, re);
    repeat (6) @(posedge pclk);
  endtask

  task automatic pulse_power();
    @(posedge pclk);
    power_cycle <= 1'b1;
    @(posedge pclk);
    power_cycle <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  // Main sequence: table first, then the awkward cases
  initial begin
    int i;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      wst(rows[i].en, rows[i].len, rows[i].d);
      rs(rows[i].rop, rows[i].exp);
    end
    chk(secure_read_only, 4'h3);
    $display("Test done: table");
    for (i = 0; i < 3; i++) begin
      // Slow bench link clock, so every code gives enough latency
      wst(8'h50, 2'h3, {4'h0, codes[i], 16'h0});
      chk(read_latency_code, codes[i]);
      chk(fast_dummy, (codes[i] == 4'h0) ? 4'h8 : codes[i]);
      chk(dio_dummy, codes[i]);
      chk(qio_dummy, (codes[i] == 4'h0) ? 4'h4 : codes[i]);
    end
    $display("Test done: latency");
    cmd(8'h75, 2'h0, 24'h0);
    chk(suspended, 1'b1);
    wst(8'h06, 2'h2, 24'h0);
    rs(flash_cfg_pkg::OP_READ_TWO, 8'h8c);
    cmd(8'h7a, 2'h0, 24'h0);
    chk(suspended, 1'b0);
    cmd(8'h75, 2'h0, 24'h0);
    pulse_power();
    chk(suspended, 1'b0);
    @(posedge pclk);
    array_busy <= 1'b1;
    wst(8'h06, 2'h1, 24'h000004);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h01);
    array_busy <= 1'b0;
    $display("Test done: suspend and busy");
    wst(8'h06, 2'h1, 24'h000080);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h80);
    pins(2'h2);
    wst(8'h50, 2'h3, 24'h010084);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h80);
    rs(flash_cfg_pkg::OP_READ_THREE, 8'h01);
    pins(2'h3);
    wst(8'h06, 2'h1, 24'h000084);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h84);
    // Quad enable set only while the host drives both pins from registers
    wst(8'h06, 2'h2, 24'h000284);
    chk(quad_lines_enable, 1'b1);
    pins(2'h0);
    chk(hold_active, 1'b0);
    wst(8'h06, 2'h1, 24'h000088);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h88);
    pins(2'h3);
    wst(8'h06, 2'h2, 24'h000084);
    pins(2'h1);
    chk(hold_active, 1'b1);
    pins(2'h3);
    $display("Test done: pin protection");
    wst(8'h06, 2'h2, 24'h000100);
    rs(flash_cfg_pkg::OP_READ_TWO, 8'h0d);
    wst(8'h06, 2'h2, 24'h0000fc);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h00);
    cmd(flash_cfg_pkg::OP_SOFT_RESET, 2'h0, 24'h0);
    rs(flash_cfg_pkg::OP_READ_TWO, 8'h0c);
    wst(8'h06, 2'h1, 24'h000004);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h04);
    wst(8'h06, 2'h2, 24'h000180);
    pulse_power();
    wst(8'h06, 2'h2, 24'h0);
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h80);
    rs(flash_cfg_pkg::OP_READ_TWO, 8'h0d);
    wst(8'h50, 2'h3, 24'h070000);
    rs(flash_cfg_pkg::OP_READ_THREE, 8'h07);
    $display("Test done: lock-down");
    apb(1'b0, 8'h10, 32'h0, rq, re);
    chk(re, 1'b1);
    chk(rq, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(secure_read_only, 4'h1);
    chk(fast_dummy, 4'h8);
    presetn <= 1'b1;
    rs(flash_cfg_pkg::OP_READ_ONE, 8'h00);
    rs(flash_cfg_pkg::OP_READ_TWO, 8'h04);
    $display("Test done: unmapped and reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
